// file: src/dgf_pkg.sv
// Constants, register map and types for the digitizer event framer
package dgf_pkg;
  // ----------------------------------------------------------------
  // Register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SWTRIG = 8'h04;
  localparam logic [7:0] REG_THRESH = 8'h08;
  localparam logic [7:0] REG_OFFSET = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_EVCNT = 8'h14;
  localparam logic [7:0] REG_TTAG = 8'h18;
  localparam logic [7:0] REG_BOARD = 8'h1c;
  // ----------------------------------------------------------------
  // Control fields
  // ----------------------------------------------------------------
  localparam int CB_RUN = 0;
  localparam int CB_CNT_ALL = 1;
  localparam int CB_FT_EN = 2;
  localparam int CB_FT_TRAIL = 3;
  localparam int CB_FT_STORE = 4;
  localparam int CB_REF_EXT = 5;
  localparam int CB_RATE_LO = 8;
  localparam int CB_GMASK_LO = 16;
  localparam logic [31:0] CTRL_RST = 32'h0003_0000;
  localparam logic [31:0] CTRL_WMASK = 32'h0003_033f;
  localparam int SB_BUSY = 0;
  localparam int SB_RING = 1;
  // ----------------------------------------------------------------
  // Rates, event layout
  // ----------------------------------------------------------------
  localparam logic [1:0] RATE_5G = 2'h0;
  localparam logic [1:0] RATE_2G5 = 2'h1;
  localparam logic [1:0] RATE_1G = 2'h2;
  localparam logic [1:0] RATE_NONE = 2'h3;
  localparam logic [3:0] HDR_MARK = 4'ha;
  localparam int HDR_MARK_LO = 28;
  localparam logic [1:0] HDR_LAST = 2'h3;
  localparam int H1_BID_LO = 27;
  localparam int H1_PAT_LO = 8;
  localparam int EVCNT_W = 24;
  localparam int BID_W = 5;
  localparam int PAT_W = 16;
  localparam int DAC_W = 16;
  localparam int NGRP = 2;
  localparam int GRP_CH = 8;
  localparam int SAMP_W = 12;
  localparam int WORD_W = 32;
  localparam int CH_W = 4;
  localparam logic [3:0] FT_CH = 4'h8;
  localparam logic [3:0] LAST_CH = 4'h7;
  localparam int D_CELL_LO = 20;
  localparam int D_RATE_LO = 16;
  localparam int D_TR = 12;
  localparam int D_SIZE_W = 12;
  localparam int TAG_CNT_W = 31;
  // ----------------------------------------------------------------
  // Framer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_HDR = 3'b001,
    S_DESC = 3'b010,
    S_DATA = 3'b011,
    S_TAG = 3'b100
  } dgf_state_t;
endpackage : dgf_pkg

// file: src/dgf_event_framer.sv
// Event framer and fast-trigger control for the switched-capacitor digitizer
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module dgf_event_framer #(
  parameter int NSAMP = 1024
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [dgf_pkg::ADDR_W-1:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic FAST_TRIG_INPUT_I,
  input wire logic [dgf_pkg::PAT_W-1:0] PATTERN_I,
  input wire logic [dgf_pkg::BID_W-1:0] BOARD_IDENTITY_I,
  output logic [2*dgf_pkg::DAC_W-1:0] FAST_TRIG_THRESHOLD_O,
  output logic [2*dgf_pkg::DAC_W-1:0] FAST_TRIG_OFFSET_O,
  output logic [1:0] SAMPLE_RATE_O,
  output logic REF_CLK_EXT_O,
  output logic RING_RUN_O,
  output logic CONV_REQ_O,
  output logic [0:0] CONV_GRP_O,
  output logic [dgf_pkg::CH_W-1:0] CONV_CH_O,
  output logic [$clog2(NSAMP)-1:0] CONV_CELL_O,
  input wire logic ADC_VALID_I,
  input wire logic [dgf_pkg::SAMP_W-1:0] ADC_DATA_I,
  output logic [31:0] EVT_DATA_O,
  output logic EVT_VALID_O,
  output logic EVT_LAST_O,
  input wire logic EVT_READY_I
);
  localparam int CELL_W = $clog2(NSAMP);
  localparam int CH_WORDS = NSAMP * 3;
  localparam int TR_WORDS = CH_WORDS / dgf_pkg::GRP_CH;
  localparam int ACC_W = dgf_pkg::WORD_W + dgf_pkg::SAMP_W;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] thresh_q;
  logic [31:0] offset_q;
  logic [31:0] wb_rdata_d;
  logic wb_hit;
  logic sw_trig;
  logic [31:0] wmask;
  logic [31:0] ctrl_new;
  logic [dgf_pkg::EVCNT_W-1:0] evcnt_q;
  logic [31:0] tag_q;
  logic [dgf_pkg::BID_W-1:0] bid_q;
  dgf_pkg::dgf_state_t st_q;

  assign wb_hit = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  assign sw_trig = wb_hit & WB_WE_I & (WB_ADR_I == dgf_pkg::REG_SWTRIG);
  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}}, {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign ctrl_new = ((ctrl_q & ~wmask) | (WB_DAT_I & wmask)) & dgf_pkg::CTRL_WMASK;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_q <= dgf_pkg::CTRL_RST;
      thresh_q <= '0;
      offset_q <= '0;
    end else if (wb_hit && WB_WE_I) begin
      case (WB_ADR_I)
        dgf_pkg::REG_CTRL: begin
          // Unused rate code is refused; the old rate stays
          if (ctrl_new[dgf_pkg::CB_RATE_LO +: 2] == dgf_pkg::RATE_NONE) begin
            ctrl_q <= {ctrl_new[31:dgf_pkg::CB_RATE_LO+2],
                       ctrl_q[dgf_pkg::CB_RATE_LO +: 2], ctrl_new[dgf_pkg::CB_RATE_LO-1:0]};
          end else begin
            ctrl_q <= ctrl_new;
          end
        end
        dgf_pkg::REG_THRESH: thresh_q <= (thresh_q & ~wmask) | (WB_DAT_I & wmask);
        dgf_pkg::REG_OFFSET: offset_q <= (offset_q & ~wmask) | (WB_DAT_I & wmask);
        default: ;
      endcase
    end
  end

  always_comb begin
    wb_rdata_d = '0;
    case (WB_ADR_I)
      dgf_pkg::REG_CTRL: wb_rdata_d = ctrl_q;
      dgf_pkg::REG_THRESH: wb_rdata_d = thresh_q;
      dgf_pkg::REG_OFFSET: wb_rdata_d = offset_q;
      dgf_pkg::REG_STATUS: begin
        wb_rdata_d[dgf_pkg::SB_BUSY] = (st_q != dgf_pkg::S_IDLE);
        wb_rdata_d[dgf_pkg::SB_RING] = RING_RUN_O;
      end
      dgf_pkg::REG_EVCNT: wb_rdata_d[dgf_pkg::EVCNT_W-1:0] = evcnt_q;
      dgf_pkg::REG_TTAG: wb_rdata_d = tag_q;
      dgf_pkg::REG_BOARD: wb_rdata_d[dgf_pkg::BID_W-1:0] = bid_q;
      default: wb_rdata_d = '0;
    endcase
  end

  // Unmapped addresses still ack, reading zero, so the bus never hangs
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= '0;
    end else begin
      WB_ACK_O <= wb_hit;
      WB_DAT_O <= wb_hit ? wb_rdata_d : '0;
    end
  end

  assign FAST_TRIG_THRESHOLD_O = thresh_q;
  assign FAST_TRIG_OFFSET_O = offset_q;
  assign SAMPLE_RATE_O = ctrl_q[dgf_pkg::CB_RATE_LO +: 2];
  assign REF_CLK_EXT_O = ctrl_q[dgf_pkg::CB_REF_EXT];

  // ----------------------------------------------------------------
  // Pin synchronisers and strap
  // ----------------------------------------------------------------
  logic ft_s1_q;
  logic ft_s2_q;
  logic ft_prev_q;
  logic [dgf_pkg::PAT_W-1:0] pat_s1_q;
  logic [dgf_pkg::PAT_W-1:0] pat_s2_q;
  logic bid_done_q;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ft_s1_q <= 1'b0;
      ft_s2_q <= 1'b0;
      ft_prev_q <= 1'b0;
      pat_s1_q <= '0;
      pat_s2_q <= '0;
    end else begin
      ft_s1_q <= FAST_TRIG_INPUT_I;
      ft_s2_q <= ft_s1_q;
      ft_prev_q <= ft_s2_q;
      pat_s1_q <= PATTERN_I;
      pat_s2_q <= pat_s1_q;
    end
  end

  // Identity is a strap, caught once after reset release
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      bid_q <= '0;
      bid_done_q <= 1'b0;
    end else if (!bid_done_q) begin
      bid_q <= BOARD_IDENTITY_I;
      bid_done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Trigger, counters and ring
  // ----------------------------------------------------------------
  logic run;
  logic run_prev_q;
  logic ft_edge;
  logic trig_any;
  logic trig_acc;
  logic [CELL_W-1:0] cell_q;

  assign run = ctrl_q[dgf_pkg::CB_RUN];
  assign ft_edge = ctrl_q[dgf_pkg::CB_FT_TRAIL] ? (ft_prev_q & ~ft_s2_q)
                                                : (~ft_prev_q & ft_s2_q);
  // Comparator output already reflects the programmed threshold
  assign trig_any = (ctrl_q[dgf_pkg::CB_FT_EN] & ft_edge) | sw_trig;
  assign trig_acc = trig_any & run & (st_q == dgf_pkg::S_IDLE);
  assign RING_RUN_O = run & (st_q == dgf_pkg::S_IDLE);

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      evcnt_q <= '0;
    end else if (trig_acc || (trig_any && ctrl_q[dgf_pkg::CB_CNT_ALL])) begin
      evcnt_q <= evcnt_q + 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      run_prev_q <= 1'b0;
      tag_q <= '0;
    end else begin
      run_prev_q <= run;
      if (run && !run_prev_q) begin
        tag_q <= '0;
      end else begin
        tag_q[dgf_pkg::TAG_CNT_W-1:0] <= tag_q[dgf_pkg::TAG_CNT_W-1:0] + 1'b1;
        tag_q[31] <= tag_q[31] | (&tag_q[dgf_pkg::TAG_CNT_W-1:0]);
      end
    end
  end

  // Ring advances while sampling and stops on the freezing trigger
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      cell_q <= '0;
    end else if (RING_RUN_O && !trig_acc) begin
      cell_q <= cell_q + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Event snapshot
  // ----------------------------------------------------------------
  logic [31:0] ev_tag_q;
  logic [dgf_pkg::EVCNT_W-1:0] ev_cnt_q;
  logic [dgf_pkg::PAT_W-1:0] ev_pat_q;
  logic [CELL_W-1:0] ev_cell_q;
  logic [1:0] ev_mask_q;
  logic [1:0] ev_rate_q;
  logic ev_tr_q;
  logic [27:0] ev_size;
  logic [27:0] grp_words;

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ev_tag_q <= '0;
      ev_cnt_q <= '0;
      ev_pat_q <= '0;
      ev_cell_q <= '0;
      ev_mask_q <= '0;
      ev_rate_q <= dgf_pkg::RATE_5G;
      ev_tr_q <= 1'b0;
    end else if (trig_acc) begin
      ev_tag_q <= tag_q;
      ev_cnt_q <= (evcnt_q + 1'b1);
      ev_pat_q <= pat_s2_q;
      ev_cell_q <= cell_q;
      ev_mask_q <= ctrl_q[dgf_pkg::CB_GMASK_LO +: 2];
      ev_rate_q <= ctrl_q[dgf_pkg::CB_RATE_LO +: 2];
      ev_tr_q <= ctrl_q[dgf_pkg::CB_FT_STORE];
    end
  end

  assign grp_words = 28'(CH_WORDS + 2) + (ev_tr_q ? 28'(TR_WORDS) : 28'h0);
  assign ev_size = 28'(4) + (ev_mask_q[0] ? grp_words : 28'h0)
                 + (ev_mask_q[1] ? grp_words : 28'h0);

  // ----------------------------------------------------------------
  // Framer
  // ----------------------------------------------------------------
  logic [1:0] hw_q;
  logic grp_q;
  logic tr_ph_q;
  logic [CELL_W:0] s_q;
  logic [dgf_pkg::CH_W-1:0] ch_q;
  logic pend_q;
  logic [ACC_W-1:0] acc_q;
  logic [5:0] nbits_q;
  logic [ACC_W-1:0] acc_ins;
  logic [5:0] nbits_ins;
  logic can_load;
  logic reqs_done;
  logic [31:0] desc;
  logic [31:0] hdr;

  assign can_load = ~EVT_VALID_O | EVT_READY_I;
  assign reqs_done = s_q[CELL_W];
  assign acc_ins = acc_q | (ACC_W'(ADC_DATA_I) << nbits_q);
  assign nbits_ins = nbits_q + 6'(dgf_pkg::SAMP_W);
  assign desc = {2'b00, 10'(ev_cell_q), 2'b00, ev_rate_q, 3'b000, ev_tr_q,
                 dgf_pkg::D_SIZE_W'(CH_WORDS)};

  always_comb begin
    case (hw_q)
      2'h0: hdr = {dgf_pkg::HDR_MARK, ev_size};
      2'h1: hdr = {bid_q, 3'b000, ev_pat_q, 6'h00, ev_mask_q};
      2'h2: hdr = {8'h00, ev_cnt_q};
      default: hdr = ev_tag_q;
    endcase
  end

  assign CONV_GRP_O = grp_q;
  assign CONV_CH_O = ch_q;
  assign CONV_CELL_O = ev_cell_q + s_q[CELL_W-1:0];

  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q <= dgf_pkg::S_IDLE;
      hw_q <= '0;
      grp_q <= 1'b0;
      tr_ph_q <= 1'b0;
      s_q <= '0;
      ch_q <= '0;
      pend_q <= 1'b0;
      acc_q <= '0;
      nbits_q <= '0;
      CONV_REQ_O <= 1'b0;
      EVT_DATA_O <= '0;
      EVT_VALID_O <= 1'b0;
      EVT_LAST_O <= 1'b0;
    end else begin
      CONV_REQ_O <= 1'b0;
      if (EVT_VALID_O && EVT_READY_I) begin
        EVT_VALID_O <= 1'b0;
        EVT_LAST_O <= 1'b0;
      end
      case (st_q)
        dgf_pkg::S_IDLE: begin
          if (trig_acc) begin
            st_q <= dgf_pkg::S_HDR;
            hw_q <= '0;
          end
        end
        dgf_pkg::S_HDR: begin
          if (can_load) begin
            EVT_DATA_O <= hdr;
            EVT_VALID_O <= 1'b1;
            hw_q <= hw_q + 1'b1;
            if (hw_q == dgf_pkg::HDR_LAST) begin
              // Lowest contributing group goes first
              grp_q <= ~ev_mask_q[0];
              EVT_LAST_O <= (ev_mask_q == 2'b00);
              st_q <= (ev_mask_q == 2'b00) ? dgf_pkg::S_IDLE : dgf_pkg::S_DESC;
            end
          end
        end
        dgf_pkg::S_DESC: begin
          if (can_load) begin
            EVT_DATA_O <= desc;
            EVT_VALID_O <= 1'b1;
            s_q <= '0;
            ch_q <= '0;
            tr_ph_q <= 1'b0;
            st_q <= dgf_pkg::S_DATA;
          end
        end
        dgf_pkg::S_DATA: begin
          // One conversion in flight; the next waits for the word slot, so
          // a stalled link throttles the converter with no buffer
          if (!pend_q && !EVT_VALID_O && !reqs_done) begin
            CONV_REQ_O <= 1'b1;
            pend_q <= 1'b1;
          end
          if (pend_q && ADC_VALID_I) begin
            pend_q <= 1'b0;
            if (tr_ph_q || ch_q == dgf_pkg::LAST_CH) begin
              ch_q <= tr_ph_q ? dgf_pkg::FT_CH : '0;
              s_q <= s_q + 1'b1;
            end else begin
              ch_q <= ch_q + 1'b1;
            end
            if (nbits_ins >= 6'(dgf_pkg::WORD_W)) begin
              EVT_DATA_O <= acc_ins[31:0];
              EVT_VALID_O <= 1'b1;
              acc_q <= acc_ins >> dgf_pkg::WORD_W;
              nbits_q <= nbits_ins - 6'(dgf_pkg::WORD_W);
            end else begin
              acc_q <= acc_ins;
              nbits_q <= nbits_ins;
            end
          end
          if (reqs_done && !pend_q) begin
            if (ev_tr_q && !tr_ph_q) begin
              tr_ph_q <= 1'b1;
              ch_q <= dgf_pkg::FT_CH;
              s_q <= '0;
            end else begin
              st_q <= dgf_pkg::S_TAG;
            end
          end
        end
        dgf_pkg::S_TAG: begin
          if (can_load) begin
            EVT_DATA_O <= ev_tag_q;
            EVT_VALID_O <= 1'b1;
            if (!grp_q && ev_mask_q[1]) begin
              grp_q <= 1'b1;
              st_q <= dgf_pkg::S_DESC;
            end else begin
              EVT_LAST_O <= 1'b1;
              st_q <= dgf_pkg::S_IDLE;
            end
          end
        end
        default: st_q <= dgf_pkg::S_IDLE;
      endcase
    end
  end

  // Link, USB and local bus clocking lives outside; this stream is the
  // hand-off point on the fixed local clock side
endmodule : dgf_event_framer

// file: sim/dgf_adc_model.sv
// Converter model answering framer sample requests, promptly or slowly
`timescale 1ns/1ps
module dgf_adc_model #(
  parameter int CW = 4
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic slow_i,
  input wire logic req_i,
  input wire logic [0:0] grp_i,
  input wire logic [3:0] ch_i,
  input wire logic [CW-1:0] cell_i,
  output logic valid_o,
  output logic [11:0] data_o
);
  logic busy_q;
  logic [2:0] wait_q;
  // Code names group, channel and cell so a misrouted sample cannot hide
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_q <= 1'b0;
      wait_q <= 3'h0;
      valid_o <= 1'b0;
      data_o <= 12'h0;
    end else if (busy_q && wait_q == 3'h0) begin
      busy_q <= 1'b0;
      valid_o <= 1'b1;
      data_o <= {grp_i, ch_i, 7'(cell_i)};
    end else begin
      valid_o <= 1'b0;
      // Outside a strobe the code keeps changing, never a stale sample
      data_o <= ~data_o;
      if (busy_q) begin
        wait_q <= wait_q - 3'h1;
      end
      if (req_i) begin
        busy_q <= 1'b1;
        wait_q <= slow_i ? 3'h5 : 3'h0;
      end
    end
  end
endmodule : dgf_adc_model

// file: sim/dgf_event_framer_properties.sv
// Port-level assertions for the digitizer event framer
`timescale 1ns/1ps
module dgf_checker #(
  parameter int NSAMP = 1024
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_ACK_O,
  input wire logic RING_RUN_O,
  input wire logic CONV_REQ_O,
  input wire logic [0:0] CONV_GRP_O,
  input wire logic [dgf_pkg::CH_W-1:0] CONV_CH_O,
  input wire logic [$clog2(NSAMP)-1:0] CONV_CELL_O,
  input wire logic ADC_VALID_I,
  input wire logic [31:0] EVT_DATA_O,
  input wire logic EVT_VALID_O,
  input wire logic EVT_LAST_O,
  input wire logic EVT_READY_I
);
  // -----
  // Event word index and outstanding conversion
  // -----
  logic [27:0] idx_q;
  logic [27:0] size_q;
  logic pend_q;
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      idx_q <= 28'h0;
      size_q <= 28'h0;
    end else if (EVT_VALID_O && EVT_READY_I) begin
      idx_q <= EVT_LAST_O ? 28'h0 : idx_q + 28'h1;
      if (idx_q == 28'h0) begin
        size_q <= EVT_DATA_O[27:0];
      end
    end
  end
  always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pend_q <= 1'b0;
    end else if (CONV_REQ_O) begin
      pend_q <= 1'b1;
    end else if (ADC_VALID_I) begin
      pend_q <= 1'b0;
    end
  end
  default clocking dck @(posedge SYS_CLK_I); endclocking
  default disable iff (!RST_N_I);
  a_ack_follows_req: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus ack missing");
  a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack too long");
  a_word_held: assert property (EVT_VALID_O && !EVT_READY_I |=>
    EVT_VALID_O && $stable(EVT_DATA_O) && $stable(EVT_LAST_O))
    else $error("event word dropped");
  a_header_mark: assert property (EVT_VALID_O && idx_q == 28'h0 |->
    EVT_DATA_O[31:28] == 4'ha)
    else $error("header marker wrong");
  a_last_at_size: assert property (EVT_VALID_O && idx_q != 28'h0 |->
    EVT_LAST_O == (idx_q == size_q - 28'h1))
    else $error("last flag off size");
  // The ring may rearm while the final word of an event still waits
  a_ring_frozen: assert property (CONV_REQ_O || (EVT_VALID_O && !EVT_LAST_O) |->
    !RING_RUN_O)
    else $error("ring runs in readout");
  a_one_conv: assert property (pend_q |-> !CONV_REQ_O)
    else $error("second request");
  a_conv_addr_held: assert property (pend_q && !ADC_VALID_I |=>
    $stable(CONV_CELL_O) && $stable(CONV_CH_O) && $stable(CONV_GRP_O))
    else $error("request address moved");
  a_channel_range: assert property (CONV_REQ_O |-> CONV_CH_O <= dgf_pkg::FT_CH)
    else $error("channel out of range");
endmodule : dgf_checker
bind dgf_event_framer dgf_checker #(.NSAMP(NSAMP)) u_dgf_checker (.*);

// file: sim/dgf_event_framer_bench.sv
// Self-checking bench for the digitizer event framer
`timescale 1ns/1ps
module dgf_event_framer_bench;
  localparam int N = 16;
  localparam int GW = 3 * N;
  localparam logic [4:0] BID = 5'h0b;
  // Rows: group mask, rate, store wave, event words, pattern
  localparam logic [28:0] ROWS [4] = '{
    {2'h3, 2'h0, 1'h0, 8'h68, 16'ha5c3},
    {2'h1, 2'h1, 1'h1, 8'h3c, 16'h0001},
    {2'h2, 2'h2, 1'h1, 8'h3c, 16'h8000},
    {2'h0, 2'h0, 1'h0, 8'h04, 16'hffff}
  };
  logic SYS_CLK_I = 1'b0;
  logic RST_N_I = 1'b0;
  logic WB_CYC_I = 1'b0;
  logic WB_STB_I = 1'b0;
  logic WB_WE_I = 1'b0;
  logic [7:0] WB_ADR_I = 8'h0;
  logic [3:0] WB_SEL_I = 4'h0;
  logic [31:0] WB_DAT_I = 32'h0;
  logic FAST_TRIG_INPUT_I = 1'b0;
  logic [15:0] PATTERN_I = 16'h0;
  logic [4:0] BOARD_IDENTITY_I = BID;
  logic EVT_READY_I = 1'b0;
  logic WB_ACK_O, REF_CLK_EXT_O, RING_RUN_O, CONV_REQ_O, ADC_VALID_I, EVT_VALID_O, EVT_LAST_O;
  logic [31:0] WB_DAT_O, FAST_TRIG_THRESHOLD_O, FAST_TRIG_OFFSET_O, EVT_DATA_O;
  logic [1:0] SAMPLE_RATE_O;
  logic [0:0] CONV_GRP_O;
  logic [3:0] CONV_CH_O, CONV_CELL_O;
  logic [11:0] ADC_DATA_I;
  logic slow = 1'b0;
  logic [1:0] ph = 2'h0;
  logic [23:0] ecnt = 24'h0;
  logic [31:0] ltag = 32'h0;
  logic [31:0] q;
  logic [31:0] got [$];
  int bad_count = 0;
  int checks_done = 0;
  always #50 SYS_CLK_I = ~SYS_CLK_I;
  dgf_event_framer #(.NSAMP(N)) u_dgf_event_framer (.*);
  dgf_adc_model #(.CW(4)) u_dgf_adc_model (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RST_N_I),
    .slow_i(slow),
    .req_i(CONV_REQ_O),
    .grp_i(CONV_GRP_O),
    .ch_i(CONV_CH_O),
    .cell_i(CONV_CELL_O),
    .valid_o(ADC_VALID_I),
    .data_o(ADC_DATA_I)
  );
  // Sink stalls one cycle in three so held words get exercised
  always @(posedge SYS_CLK_I) begin
    ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
    EVT_READY_I <= (ph != 2'h0);
    if (EVT_VALID_O === 1'b1 && EVT_READY_I === 1'b1) begin
      got.push_back(EVT_DATA_O);
    end
  end
  // -----
  // Tasks
  // -----
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= w;
    WB_ADR_I <= a;
    WB_SEL_I <= s;
    WB_DAT_I <= d;
    do begin
      @(posedge SYS_CLK_I);
      n++;
    end while (WB_ACK_O !== 1'b1 && n < 16);
    q = WB_DAT_O;
    chk("ack", 32'h1, {31'h0, WB_ACK_O});
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
    @(posedge SYS_CLK_I);
  endtask : wb
  task automatic chk_ev(input logic [1:0] m, input logic [1:0] rt, input logic st,
                        input logic [7:0] sz, input logic [15:0] p);
    int w;
    logic [31:0] t;
    logic [9:0] sc;
    logic [GW*32-1:0] pk;
    w = 0;
    while (got.size() < int'(sz) && w < 5000) begin
      @(posedge SYS_CLK_I);
      w++;
    end
    chk("rate", {30'h0, rt}, {30'h0, SAMPLE_RATE_O});
    chk("size", {4'ha, 20'h0, sz}, got[0]);
    chk("ident", {BID, 3'h0, p, 6'h0, m}, got[1]);
    chk("counter", {8'h0, ecnt}, got[2]);
    t = got[3];
    chk("tag", 32'h1, {31'h0, t > ltag && !t[31]});
    ltag = t;
    w = 4;
    for (int g = 0; g < 2; g++) begin
      if (m[g]) begin
        sc = got[w][29:20];
        chk("desc", {2'h0, sc, 2'h0, rt, 3'h0, st, 12'(GW)}, got[w]);
        for (int k = 0; k < 8 * N; k++) begin
          pk[k*12 +: 12] = {g[0], 4'(k % 8), 7'((sc + k / 8) % N)};
        end
        for (int j = 0; j < GW; j++) begin
          chk("sample", pk[j*32 +: 32], got[w+1+j]);
        end
        w = w + GW + 1;
        if (st) begin
          for (int k = 0; k < N; k++) begin
            pk[k*12 +: 12] = {g[0], dgf_pkg::FT_CH, 7'((sc + k) % N)};
          end
          for (int j = 0; j < GW / 8; j++) begin
            chk("wave", pk[j*32 +: 32], got[w+j]);
          end
          w = w + GW / 8;
        end
        chk("group tag", t, got[w]);
        w++;
      end
    end
    chk("length", {24'h0, sz}, w);
    got.delete();
  endtask : chk_ev
  // -----
  // Sequence
  // -----
  initial begin
    repeat (60000) @(posedge SYS_CLK_I);
    bad_count++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    @(posedge SYS_CLK_I);
    for (int i = 0; i < 4; i++) begin
      slow <= i[0];
      PATTERN_I <= ROWS[i][15:0];
      wb(1'b1, dgf_pkg::REG_CTRL, {14'h0, ROWS[i][28:27], 6'h0, ROWS[i][26:25], 3'h0,
         ROWS[i][24], 4'h1}, 4'hf);
      chk("ring", 32'h1, {31'h0, RING_RUN_O});
      wb(1'b1, dgf_pkg::REG_SWTRIG, 32'h0, 4'hf);
      ecnt++;
      chk_ev(ROWS[i][28:27], ROWS[i][26:25], ROWS[i][24], ROWS[i][23:16], ROWS[i][15:0]);
    end
    // Rising pin fires only in leading mode; trailing mode waits for the fall
    for (int e = 0; e < 2; e++) begin
      wb(1'b1, dgf_pkg::REG_CTRL, 32'h0003_0005 | (32'(e) << 3), 4'hf);
      FAST_TRIG_INPUT_I <= 1'b1;
      repeat (8) @(posedge SYS_CLK_I);
      wb(1'b0, dgf_pkg::REG_STATUS, 32'h0, 4'hf);
      chk("edge busy", 32'(1 - e), {31'h0, q[0]});
      FAST_TRIG_INPUT_I <= 1'b0;
      ecnt++;
      chk_ev(2'h3, 2'h0, 1'b0, 8'h68, 16'hffff);
    end
    // Second trigger lands while busy: counted only in count-all mode
    for (int c = 0; c < 2; c++) begin
      wb(1'b1, dgf_pkg::REG_CTRL, 32'h0003_0001 | (32'(c) << 1), 4'hf);
      wb(1'b1, dgf_pkg::REG_SWTRIG, 32'h0, 4'hf);
      wb(1'b1, dgf_pkg::REG_SWTRIG, 32'h0, 4'hf);
      ecnt++;
      chk_ev(2'h3, 2'h0, 1'b0, 8'h68, 16'hffff);
      ecnt = ecnt + 24'(c);
      wb(1'b0, dgf_pkg::REG_EVCNT, 32'h0, 4'hf);
      chk("count all", {8'h0, ecnt}, q);
    end
    wb(1'b1, dgf_pkg::REG_THRESH, 32'h1234_5678, 4'hf);
    wb(1'b1, dgf_pkg::REG_THRESH, 32'hffff_ffff, 4'h3);
    chk("threshold", 32'h1234_ffff, FAST_TRIG_THRESHOLD_O);
    wb(1'b1, dgf_pkg::REG_OFFSET, 32'h00aa_5500, 4'hf);
    chk("offset", 32'h00aa_5500, FAST_TRIG_OFFSET_O);
    wb(1'b1, dgf_pkg::REG_CTRL, 32'h0003_0321, 4'hf);
    chk("rate kept", 32'h0, {30'h0, SAMPLE_RATE_O});
    chk("ref source", 32'h1, {31'h0, REF_CLK_EXT_O});
    wb(1'b1, 8'h20, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h20, 32'h0, 4'hf);
    chk("unmapped", 32'h0, q);
    RST_N_I <= 1'b0;
    repeat (3) @(posedge SYS_CLK_I);
    RST_N_I <= 1'b1;
    @(posedge SYS_CLK_I);
    wb(1'b0, dgf_pkg::REG_CTRL, 32'h0, 4'hf);
    chk("ctrl reset", dgf_pkg::CTRL_RST, q);
    wb(1'b0, dgf_pkg::REG_EVCNT, 32'h0, 4'hf);
    chk("count reset", 32'h0, q);
    wb(1'b0, dgf_pkg::REG_BOARD, 32'h0, 4'hf);
    chk("board", {27'h0, BID}, q);
    wb(1'b1, dgf_pkg::REG_CTRL, 32'h0003_0001, 4'hf);
    wb(1'b0, dgf_pkg::REG_TTAG, 32'h0, 4'hf);
    chk("tag restart", 32'h1, {31'h0, q < 32'h8});
    complete_run();
  end
endmodule : dgf_event_framer_bench
